// File: src/tcc_pkg.sv
// constants, register indices and types for the camera control registers
package tcc_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IX_OPCTL  = 16'h0001;
  localparam logic [15:0] IX_STATUS = 16'h0003;
  localparam logic [15:0] IX_LAYOUT = 16'h0004;
  localparam logic [15:0] IX_EXP0   = 16'h0005;
  localparam logic [15:0] IX_HWID   = 16'h0006;
  localparam logic [15:0] IX_FREQ0  = 16'h0009;
  localparam logic [15:0] IX_UNLOCK = 16'h0022;
  localparam logic [15:0] IX_TLIMIT = 16'h0024;
  localparam logic [15:0] IX_FLCMD  = 16'h0033;
  localparam logic [15:0] IX_SEQCNT = 16'h0040;
  localparam logic [15:0] IX_EXP1   = 16'h0041; // exp1..exp3
  localparam logic [15:0] IX_FREQ1  = 16'h0044; // freq1..freq3
  localparam logic [15:0] IX_PROC   = 16'h0048;
  localparam logic [15:0] IX_READY  = 16'h0049;
  localparam logic [15:0] IX_OFFS   = 16'h0050; // 14 offsets
  localparam logic [15:0] IX_STN    = 16'h0060; // 3 address words
  localparam logic [15:0] IX_IPHI   = 16'h0064;
  localparam logic [15:0] IX_IPLO   = 16'h0065;
  localparam logic [15:0] IX_MSKHI  = 16'h0066;
  localparam logic [15:0] IX_MSKLO  = 16'h0067;
  localparam logic [15:0] IX_GWHI   = 16'h0068;
  localparam logic [15:0] IX_GWLO   = 16'h0069;
  localparam logic [15:0] IX_UDPPRT = 16'h006a;
  localparam logic [15:0] IX_FWREV  = 16'h8000;
  // field positions
  localparam int OP_VIDEO = 0;
  localparam int OP_TRIG  = 4;
  localparam int OP_CLR   = 6;
  localparam int ST_TFLT  = 3;
  localparam int ST_CAL   = 5;
  localparam int ST_FACT  = 6;
  localparam int ST_OVT   = 9;
  localparam int ST_BFLT  = 14;
  localparam int ST_SFLT  = 15;
  localparam int LAY_LO   = 3;
  localparam int LAY_HI   = 10;
  localparam int PROC_OFS = 0;
  localparam int RDY_BIT  = 1;
  // values after reset and the sequence count limit
  localparam logic [15:0] OPCTL_RST  = 16'h0001;
  localparam logic [15:0] LAYOUT_RST = 16'h0000;
  localparam logic [15:0] EXP_RST    = 16'h05dc;
  localparam logic [15:0] FREQ_RST   = 16'h07d0;
  localparam logic [15:0] TLIMIT_RST = 16'h1b58;
  localparam logic [2:0]  SEQCNT_RST = 3'h1;
  localparam logic [2:0]  SEQ_MAX    = 3'h4;
  // temperature release hysteresis, 2.00 degrees in 0.01 steps
  localparam logic [15:0] TEMP_HYST  = 16'h00c8;
  // unlock value, flash command codes and number of predefined frequencies
  localparam logic [15:0] KEY_FLASH  = 16'h4877;
  localparam logic [15:0] FCMD_SAVE  = 16'h0001;
  localparam logic [15:0] FCMD_ERASE = 16'h0002;
  localparam int NFREQ = 14;
  // predefined carrier frequencies in 10 kHz steps, ascending
  localparam logic [15:0] FREQ_TAB [NFREQ] = '{
    16'h00e5, 16'h01f4, 16'h02ee, 16'h03e9, 16'h05dc, 16'h07d1,
    16'h09c6, 16'h0bb8, 16'h0fa3, 16'h138b, 16'h1770, 16'h1b58,
    16'h1e7e, 16'h1f45};
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00, SQ_WAIT = 2'b01} tcc_seq_e;
  typedef enum logic [1:0] {
    FL_BOOT = 2'b00, FL_BUSY = 2'b01, FL_IDLE = 2'b10} tcc_fl_e;
  typedef enum logic [1:0] {
    FOP_RESTORE = 2'b00, FOP_SAVE = 2'b01, FOP_ERASE = 2'b10} tcc_fop_e;
endpackage : tcc_pkg

// File: src/tcc_control_regs.sv
// register bank, exposure sequencer and protection of the tof camera
// Summary of operation
// - one to four back-to-back exposure sequences
// - each sequence uses its own exposure pair
// - manual trigger captures configured sequence count
// - each frame carries its sequence index
// - one offset for each of the fourteen frequencies, subtracted
// - offset correction switched by processing bit
// - manual trigger only when video bit zero
// - control bit 4 triggers, self-clears
// - over-temperature halts light and stream
// - register map saved and restored via flash
// - ready bit set after settings applied
// - user station address overrides factory one
// - ip settings commit on gateway write
// - factory-reset command erases stored map
// - temperature sensor fault bits auto-clear
// - status bit 5 flags missing calibration
// - status bit 15 flags sensor module fault
// - control bit 6 clears status, self-clears
// - layout field selects output format
// - critical commands need unlock key first
// - frequency in 10 kHz, reads selected value
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tcc_control_regs #(
  parameter logic [15:0] HW_IDENT = 16'h1234, // arbitrary value
  parameter logic [15:0] FW_REV   = 16'h0841, // arbitrary value
  parameter logic [47:0] FACT_STN = 48'h0200_0000_0001 // arbitrary
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic [17:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hwTrigger,
  input  wire logic        seqDone,
  input  wire logic        sensorFault,
  input  wire logic [15:0] illumTemp,
  input  wire logic        illumTempFault,
  input  wire logic        boardTempFault,
  input  wire logic        calibMissing,
  input  wire logic        flashDone,
  output logic             capStart,
  output logic      [1:0]  capSeq,
  output logic      [15:0] capExposure,
  output logic      [15:0] capFreq,
  output logic      [15:0] rangeOffset,
  output logic             offsetEn,
  output logic      [7:0]  layout,
  output logic             frameValid,
  output logic      [1:0]  frameSeqIdx,
  output logic             illumEn,
  output logic             streamEn,
  output logic             flashReq,
  output logic      [1:0]  flashOp,
  output logic      [47:0] stationAddr,
  output logic      [31:0] ipAddr,
  output logic      [31:0] netMask,
  output logic      [31:0] gateway,
  output logic      [15:0] udpPort
);
  import tcc_pkg::*;

  logic [15:0] opCtl_q, layout_q, tLimit_q, unlock_q, proc_q;
  logic [15:0] expo_q [4];       // exposure per sequence
  logic [3:0]  fIdx_q [4];       // selected frequency index
  logic [15:0] offs_q [NFREQ];   // range offsets in mm
  logic [15:0] stn_q  [3];       // user station address words
  logic [15:0] ipHi_q, ipLo_q, mkHi_q, mkLo_q, gwHi_q;
  logic [2:0]  seqCnt_q, burst_q;
  logic [1:0]  cur_q;            // sequence now capturing
  logic        stnUser_q, ready_q, fact_q, overT_q;
  logic        trS1_q, trS2_q, trS3_q;
  logic        pready_q, pslverr_q, capStart_q, frameValid_q;
  logic [31:0] prdata_q;
  logic [15:0] rdMux, stat;
  logic        rdHit, wr, hwEdge, go, overN, flCmdOk, clrSt;
  logic [15:0] idx, wd;
  tcc_seq_e    sq_q;
  tcc_fl_e     fl_q;
  tcc_fop_e    flOp_q;

  // pick the lowest predefined frequency not below the request
  function automatic logic [3:0] snapFreq(input logic [15:0] v);
    snapFreq = 4'hd;
    for (int i = NFREQ - 1; i >= 0; i--) begin
      if (FREQ_TAB[i] >= v) snapFreq = 4'(i);
    end
  endfunction : snapFreq

  // bus decode helpers
  assign idx = paddr[17:2];
  assign wd  = pwdata[15:0];
  assign wr  = psel & penable & pwrite & pready_q;
  // status clear request from control bit 6
  assign clrSt = wr && idx == IX_OPCTL && wd[OP_CLR];
  // flash command is honoured only after the unlock key
  assign flCmdOk = wr && idx == IX_FLCMD && unlock_q == KEY_FLASH;

  // status word, live fault bits clear on their own
  always_comb begin
    stat = 16'h0000;
    stat[ST_TFLT] = illumTempFault;
    stat[ST_BFLT] = boardTempFault;
    stat[ST_CAL]  = calibMissing;
    stat[ST_SFLT] = sensorFault;
    stat[ST_OVT]  = overT_q;
    stat[ST_FACT] = fact_q;
  end

  // read multiplexer
  always_comb begin
    rdMux = 16'h0000;
    rdHit = 1'b1;
    if (idx == IX_OPCTL) begin
      rdMux = {opCtl_q[15:7], 1'b0, opCtl_q[5], 1'b0,
               opCtl_q[3:0]};
    end else if (idx == IX_STATUS) begin
      rdMux = stat;
    end else if (idx == IX_LAYOUT) begin
      rdMux = layout_q;
    end else if (idx == IX_EXP0) begin
      rdMux = expo_q[0];
    end else if (idx == IX_HWID) begin
      rdMux = HW_IDENT;
    end else if (idx == IX_FREQ0) begin
      rdMux = FREQ_TAB[fIdx_q[0]];
    end else if (idx == IX_UNLOCK) begin
      rdMux = unlock_q;
    end else if (idx == IX_TLIMIT) begin
      rdMux = tLimit_q;
    end else if (idx == IX_FLCMD) begin
      rdMux = 16'h0000;
    end else if (idx == IX_SEQCNT) begin
      rdMux = {13'h0000, seqCnt_q};
    end else if (idx >= IX_EXP1 && idx < IX_EXP1 + 16'h0003) begin
      rdMux = expo_q[2'(idx - IX_EXP1 + 16'h0001)];
    end else if (idx >= IX_FREQ1 && idx < IX_FREQ1 + 16'h0003) begin
      rdMux = FREQ_TAB[fIdx_q[2'(idx - IX_FREQ1 + 16'h0001)]];
    end else if (idx == IX_PROC) begin
      rdMux = proc_q;
    end else if (idx == IX_READY) begin
      rdMux = 16'(ready_q) << RDY_BIT;
    end else if (idx >= IX_OFFS && idx < IX_OFFS + 16'(NFREQ)) begin
      rdMux = offs_q[4'(idx - IX_OFFS)];
    end else if (idx >= IX_STN && idx < IX_STN + 16'h0003) begin
      rdMux = stn_q[2'(idx - IX_STN)];
    end else if (idx == IX_IPHI) begin
      rdMux = ipHi_q;
    end else if (idx == IX_IPLO) begin
      rdMux = ipLo_q;
    end else if (idx == IX_MSKHI) begin
      rdMux = mkHi_q;
    end else if (idx == IX_MSKLO) begin
      rdMux = mkLo_q;
    end else if (idx == IX_GWHI) begin
      rdMux = gwHi_q;
    end else if (idx == IX_GWLO) begin
      rdMux = gateway[15:0];
    end else if (idx == IX_UDPPRT) begin
      rdMux = udpPort;
    end else if (idx == IX_FWREV) begin
      rdMux = FW_REV;
    end else begin
      rdHit = 1'b0; // unmapped
    end
    if (paddr[1:0] != 2'b00) rdHit = 1'b0;
  end

  // apb answer: no wait state, data and error staged in setup
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready_q <= psel & ~penable;
      if (psel & ~penable) begin
        pslverr_q <= ~rdHit;
        prdata_q  <= (pwrite | ~rdHit) ? 32'h0 : {16'h0000, rdMux};
      end
    end
  end

  // control, layout, limits, key and processing options
  always_ff @(posedge mclk) begin
    if (reset) begin
      opCtl_q  <= OPCTL_RST;
      layout_q <= LAYOUT_RST;
      tLimit_q <= TLIMIT_RST;
      unlock_q <= 16'h0000;
      proc_q   <= 16'h0001;
      seqCnt_q <= SEQCNT_RST;
    end else if (clkEn) begin
      // trigger and clear bits drop once taken
      opCtl_q[OP_TRIG] <= 1'b0;
      opCtl_q[OP_CLR]  <= 1'b0;
      if (wr) begin
        if (idx == IX_OPCTL) opCtl_q <= wd;
        else if (idx == IX_LAYOUT) layout_q <= wd;
        else if (idx == IX_TLIMIT) tLimit_q <= wd;
        else if (idx == IX_UNLOCK) unlock_q <= wd;
        else if (idx == IX_PROC) proc_q <= wd;
        else if (idx == IX_SEQCNT) begin
          // clamp the count into one to four
          if (wd == 16'h0000) seqCnt_q <= 3'h1;
          else if (wd > 16'(SEQ_MAX)) seqCnt_q <= SEQ_MAX;
          else seqCnt_q <= wd[2:0];
        end
      end
    end
  end

  // per-sequence exposure and frequency, range offsets
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        expo_q[i] <= EXP_RST;
        fIdx_q[i] <= snapFreq(FREQ_RST);
      end
      for (int i = 0; i < NFREQ; i++) offs_q[i] <= 16'h0000;
    end else if (clkEn && wr) begin
      if (idx == IX_EXP0) expo_q[0] <= wd;
      else if (idx == IX_FREQ0) fIdx_q[0] <= snapFreq(wd);
      else if (idx >= IX_EXP1 && idx < IX_EXP1 + 16'h0003)
        expo_q[2'(idx - IX_EXP1 + 16'h0001)] <= wd;
      else if (idx >= IX_FREQ1 && idx < IX_FREQ1 + 16'h0003)
        fIdx_q[2'(idx - IX_FREQ1 + 16'h0001)] <= snapFreq(wd);
      else if (idx >= IX_OFFS && idx < IX_OFFS + 16'(NFREQ))
        offs_q[4'(idx - IX_OFFS)] <= wd;
    end
  end

  // network settings: ip trio staged until the gateway lands
  always_ff @(posedge mclk) begin
    if (reset) begin
      ipHi_q <= 16'h0000;
      ipLo_q <= 16'h0000;
      mkHi_q <= 16'h0000;
      mkLo_q <= 16'h0000;
      gwHi_q <= 16'h0000;
      ipAddr <= 32'h0000_0000;
      netMask <= 32'h0000_0000;
      gateway <= 32'h0000_0000;
      udpPort <= 16'h0000;
    end else if (clkEn && wr) begin
      if (idx == IX_IPHI) ipHi_q <= wd;
      else if (idx == IX_IPLO) ipLo_q <= wd;
      else if (idx == IX_MSKHI) mkHi_q <= wd;
      else if (idx == IX_MSKLO) mkLo_q <= wd;
      else if (idx == IX_GWHI) gwHi_q <= wd;
      else if (idx == IX_GWLO) begin
        ipAddr  <= {ipHi_q, ipLo_q};
        netMask <= {mkHi_q, mkLo_q};
        gateway <= {gwHi_q, wd};
      end else if (idx == IX_UDPPRT) udpPort <= wd;
    end
  end

  // station address words and factory fallback
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) stn_q[i] <= 16'h0000;
      stnUser_q   <= 1'b0;
      stationAddr <= FACT_STN;
    end else if (clkEn) begin
      if (wr && idx >= IX_STN && idx < IX_STN + 16'h0003) begin
        stn_q[2'(idx - IX_STN)] <= wd;
        stnUser_q <= 1'b1;
      end else if (flCmdOk && wd == FCMD_ERASE) begin
        stnUser_q <= 1'b0;
      end
      stationAddr <= stnUser_q ? {stn_q[0], stn_q[1], stn_q[2]}
                               : FACT_STN;
    end
  end

  // flash engine requests: restore at boot, save and erase on command
  always_ff @(posedge mclk) begin
    if (reset) begin
      fl_q    <= FL_BOOT;
      flOp_q  <= FOP_RESTORE;
      flashReq <= 1'b0;
      ready_q <= 1'b0;
      fact_q  <= 1'b1;
    end else if (clkEn) begin
      flashReq <= 1'b0;
      if (clrSt) fact_q <= 1'b0;
      case (fl_q)
        FL_BOOT: begin
          flashReq <= 1'b1;
          flOp_q   <= FOP_RESTORE;
          fl_q     <= FL_BUSY;
        end
        FL_BUSY: begin
          if (flashDone) begin
            fl_q <= FL_IDLE;
            if (flOp_q == FOP_RESTORE) ready_q <= 1'b1;
            if (flOp_q == FOP_ERASE) fact_q <= 1'b1;
          end
        end
        FL_IDLE: begin
          if (flCmdOk && (wd == FCMD_SAVE || wd == FCMD_ERASE)) begin
            flashReq <= 1'b1;
            flOp_q   <= wd == FCMD_SAVE ? FOP_SAVE : FOP_ERASE;
            fl_q     <= FL_BUSY;
          end
        end
        default: fl_q <= FL_IDLE;
      endcase
    end
  end

  // hardware trigger pin synchroniser and edge detect
  always_ff @(posedge mclk) begin
    if (reset) begin
      trS1_q <= 1'b0;
      trS2_q <= 1'b0;
      trS3_q <= 1'b0;
    end else if (clkEn) begin
      trS1_q <= hwTrigger;
      trS2_q <= trS1_q;
      trS3_q <= trS2_q;
    end
  end
  assign hwEdge = trS2_q & ~trS3_q;

  // over-temperature with release hysteresis
  always_comb begin
    overN = overT_q;
    if (illumTemp > tLimit_q) overN = 1'b1;
    else if (illumTemp < tLimit_q - TEMP_HYST) overN = 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      overT_q  <= 1'b0;
      illumEn  <= 1'b1;
      streamEn <= 1'b1;
    end else if (clkEn) begin
      overT_q  <= overN;
      illumEn  <= ~overN;
      streamEn <= ~overN;
    end
  end

  // burst start: video runs free, manual waits for a trigger
  assign go = ~overT_q & ready_q &
              (opCtl_q[OP_VIDEO] |
               opCtl_q[OP_TRIG] | hwEdge);

  // exposure sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      sq_q         <= SQ_IDLE;
      burst_q      <= SEQCNT_RST;
      cur_q        <= 2'h0;
      capStart_q   <= 1'b0;
      frameValid_q <= 1'b0;
      frameSeqIdx  <= 2'h0;
      capExposure  <= EXP_RST;
      capFreq      <= FREQ_RST;
      rangeOffset  <= 16'h0000;
    end else if (clkEn) begin
      capStart_q   <= 1'b0;
      frameValid_q <= 1'b0;
      case (sq_q)
        SQ_IDLE: begin
          if (go) begin
            burst_q     <= seqCnt_q;
            cur_q       <= 2'h0;
            capStart_q  <= 1'b1;
            capExposure <= expo_q[0];
            capFreq     <= FREQ_TAB[fIdx_q[0]];
            rangeOffset <= offs_q[fIdx_q[0]];
            sq_q        <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (seqDone) begin
            frameValid_q <= 1'b1;
            frameSeqIdx  <= cur_q;
            if (3'(cur_q) + 3'h1 < burst_q) begin
              cur_q       <= cur_q + 2'h1;
              capStart_q  <= 1'b1;
              capExposure <= expo_q[cur_q + 2'h1];
              capFreq     <= FREQ_TAB[fIdx_q[cur_q + 2'h1]];
              rangeOffset <= offs_q[fIdx_q[cur_q + 2'h1]];
            end else begin
              sq_q <= SQ_IDLE;
            end
          end
        end
        default: sq_q <= SQ_IDLE;
      endcase
    end
  end

  // output ports
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign capStart   = capStart_q;
  assign capSeq     = cur_q;
  assign frameValid = frameValid_q;
  assign offsetEn   = proc_q[PROC_OFS];
  assign layout     = layout_q[LAY_HI:LAY_LO];
  assign flashOp    = flOp_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence sTrigWr;
    clkEn && wr && idx == IX_OPCTL && wd[OP_TRIG];
  endsequence
  sequence sClrWr;
    clkEn && clrSt;
  endsequence
  a_seq_bound: assert property (capStart_q |-> 3'(cur_q) < burst_q)
    else $error("sequence index beyond count");
  a_seq0_expo: assert property (capStart_q && cur_q == 2'h0
    |-> capExposure == $past(expo_q[0]))
    else $error("sequence 0 exposure wrong");
  a_manual_hold: assert property (clkEn && sq_q == SQ_IDLE &&
    !opCtl_q[OP_VIDEO] && !opCtl_q[OP_TRIG] && !hwEdge
    |=> !capStart_q)
    else $error("capture without trigger");
  a_trig_clear: assert property (sTrigWr ##1 clkEn
    |=> !opCtl_q[OP_TRIG])
    else $error("trigger bit stuck");
  a_frame_index: assert property (frameValid_q
    |-> frameSeqIdx == $past(cur_q))
    else $error("frame index mismatch");
  a_overtemp_halt: assert property (clkEn &&
    illumTemp > tLimit_q |=> overT_q && !illumEn && !streamEn)
    else $error("over-temperature not handled");
  // a finished erase in the clearing cycle wins over the clear
  a_status_clear: assert property (sClrWr
    |=> !fact_q ||
    $past(flashDone && fl_q == FL_BUSY && flOp_q == FOP_ERASE))
    else $error("status not cleared");
  a_unlock_gate: assert property ($rose(flashReq) &&
    $past(fl_q) == FL_IDLE |-> $past(unlock_q) == KEY_FLASH)
    else $error("flash command without key");
  a_ready_boot: assert property ($rose(ready_q)
    |-> $past(flashDone) && $past(flOp_q) == FOP_RESTORE)
    else $error("ready before restore done");
  a_net_commit: assert property (!$stable(ipAddr)
    |-> $past(wr && idx == IX_GWLO))
    else $error("ip changed without gateway write");
endmodule : tcc_control_regs
`default_nettype wire

// File: tb/tcc_sensor_model.sv
// sensor module and flash engine model facing the register bank
`timescale 1ns/1ps
`default_nettype none
module tcc_sensor_model (
  input  wire logic       mclk,
  input  wire logic       capStart,
  input  wire logic       flashReq,
  input  wire logic [3:0] lat,
  output logic            seqDone,
  output logic            flashDone
);
  int capCnt; // cycles left in the running capture
  int flCnt;  // cycles left in the running flash operation
  initial begin
    seqDone = 1'b0;
    flashDone = 1'b0;
    capCnt = 0;
    flCnt = 0;
  end
  // one done pulse per request, lat+1 cycles after it is sampled; lat sets prompt or slow
  always @(posedge mclk) begin
    seqDone <= (capCnt == 1);
    flashDone <= (flCnt == 1);
    capCnt <= capStart ? int'(lat) + 1 : (capCnt > 0 ? capCnt - 1 : 0);
    flCnt <= flashReq ? int'(lat) + 1 : (flCnt > 0 ? flCnt - 1 : 0);
  end
endmodule : tcc_sensor_model
`default_nettype wire

// File: tb/tcc_control_regs_test.sv
// self-checking bench for the camera control register bank
`timescale 1ns/1ps
`default_nettype none
module tcc_control_regs_test;
  import tcc_pkg::*;
  localparam logic [47:0] STN = 48'h0200_00ab_cdef; // arbitrary value
  logic mclk, reset, clkEn, psel, penable, pwrite, hwTrigger, err;
  logic sensorFault, illumTempFault, boardTempFault, calibMissing;
  logic pready, pslverr, seqDone, flashDone, capStart, frameValid;
  logic offsetEn, illumEn, streamEn, flashReq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, ipAddr, netMask, gateway, rd;
  logic [15:0] illumTemp, capExposure, capFreq, rangeOffset, udpPort;
  logic [1:0]  capSeq, frameSeqIdx, flashOp, lastOp;
  logic [7:0]  layout;
  logic [47:0] stationAddr;
  logic [3:0]  lat;
  logic        chkCap; // compare capture data against the model
  int bad_count, n_tests, capN, flN, rs, base, r;
  int expE[4], expK[4], expO[14], fq[$];
  int codes[9] = '{0, 3, 4, 7, 9, 10, 11, 12, 13};
  logic [15:0] tmp[3] = '{16'h1b59, 16'h1a90, 16'h1a8f};
  int ovt[3] = '{1, 1, 0};
  tcc_control_regs #(.FACT_STN(STN)) tcc_control_regs_i (
    .mclk(mclk), .reset(reset), .clkEn(clkEn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hwTrigger(hwTrigger), .seqDone(seqDone), .sensorFault(sensorFault),
    .illumTemp(illumTemp), .illumTempFault(illumTempFault),
    .boardTempFault(boardTempFault), .calibMissing(calibMissing),
    .flashDone(flashDone), .capStart(capStart), .capSeq(capSeq),
    .capExposure(capExposure), .capFreq(capFreq),
    .rangeOffset(rangeOffset), .offsetEn(offsetEn), .layout(layout),
    .frameValid(frameValid), .frameSeqIdx(frameSeqIdx),
    .illumEn(illumEn), .streamEn(streamEn), .flashReq(flashReq),
    .flashOp(flashOp), .stationAddr(stationAddr), .ipAddr(ipAddr),
    .netMask(netMask), .gateway(gateway), .udpPort(udpPort));
  tcc_sensor_model tcc_sensor_model_i (.mclk(mclk), .capStart(capStart),
    .flashReq(flashReq), .lat(lat), .seqDone(seqDone),
    .flashDone(flashDone));
  // compare one result and count it
  task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer: setup, access held until pready
  task automatic apb(logic w, logic [15:0] ix, logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(logic [15:0] ix, logic [15:0] d);
    apb(1'b1, ix, d);
  endtask : wr
  task automatic rdc(string nm, logic [15:0] ix, logic [31:0] e);
    apb(1'b0, ix, 16'h0000);
    chk(nm, e, rd);
  endtask : rdc
  // xorshift source, seeded with 93
  function automatic int xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  // index of lowest predefined frequency not below v, else the highest
  function automatic int snap(int v);
    for (int i = 0; i < NFREQ; i++)
      if (int'(FREQ_TAB[i]) >= v) return i;
    return NFREQ - 1;
  endfunction : snap
  // wait for a new flash request, then 20 cycles for its completion
  task automatic wfl(int b);
    for (int t = 0; t < 100 && flN == b; t++) @(posedge mclk);
    repeat (20) @(posedge mclk);
  endtask : wfl
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // capture, frame and flash monitor against the model
  always @(posedge mclk) begin
    if (capStart === 1'b1) begin
      capN++;
      fq.push_back(capSeq);
      if (chkCap) begin
        chk("capExposure", expE[capSeq], capExposure);
        chk("capFreq", FREQ_TAB[expK[capSeq]], capFreq);
        chk("rangeOffset", expO[expK[capSeq]], rangeOffset);
      end
    end
    if (frameValid === 1'b1)
      chk("frameSeqIdx", fq.pop_front(), frameSeqIdx);
    if (flashReq === 1'b1) begin
      flN++;
      lastOp = flashOp;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #3000000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, hwTrigger, sensorFault} = '0;
    {illumTempFault, boardTempFault, calibMissing, chkCap} = '0;
    paddr = '0;
    pwdata = '0;
    illumTemp = 16'h0bb8;
    clkEn = 1'b1;
    reset = 1'b1;
    lat = 4'h1;
    rs = 93;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rdc("opctl", IX_OPCTL, 32'h0001);
    rdc("status", IX_STATUS, 32'h0040);
    rdc("layout", IX_LAYOUT, 32'h0000);
    rdc("exp0", IX_EXP0, 32'h05dc);
    rdc("freq0", IX_FREQ0, 32'h07d1);
    rdc("tlimit", IX_TLIMIT, 32'h1b58);
    apb(1'b0, 16'h0002, 16'h0000);
    chk("pslverr", 1, err);
    chk("offsetEn", 1, offsetEn);
    rd = '0;
    for (int t = 0; t < 50 && rd[RDY_BIT] !== 1'b1; t++)
      apb(1'b0, IX_READY, 16'h0000);
    chk("ready", 1, rd[RDY_BIT]);
    chk("bootOp", FOP_RESTORE, lastOp);
    $display("test reset and boot done");
    wr(IX_OPCTL, 16'h0000);
    wr(IX_SEQCNT, 16'h0007);
    rdc("seqcnt", IX_SEQCNT, 32'h4);
    for (int i = 0; i < 4; i++) begin
      r = xs() & 32'h1fff;
      expK[i] = snap(r);
      expE[i] = xs() & 32'hffff;
      wr(i == 0 ? IX_FREQ0 : IX_FREQ1 + 16'(i - 1), 16'(r));
      rdc("freq", i == 0 ? IX_FREQ0 : IX_FREQ1 + 16'(i - 1),
          FREQ_TAB[expK[i]]);
      wr(i == 0 ? IX_EXP0 : IX_EXP1 + 16'(i - 1), 16'(expE[i]));
    end
    for (int i = 0; i < NFREQ; i++) begin
      expO[i] = xs() & 32'hffff;
      wr(IX_OFFS + 16'(i), 16'(expO[i]));
    end
    chkCap = 1'b1;
    for (int n = 3; n <= 4; n++) begin
      lat <= 4'(n * 2);
      wr(IX_SEQCNT, 16'(n));
      base = capN;
      if (n == 3) begin
        wr(IX_OPCTL, 16'h0010);
      end else begin
        hwTrigger <= 1'b1;
        repeat (4) @(posedge mclk);
        hwTrigger <= 1'b0;
      end
      wr(IX_OPCTL, 16'h0010);
      for (int t = 0; t < 300 && capN - base < n; t++) @(posedge mclk);
      repeat (30) @(posedge mclk);
      chk("captures", n, capN - base);
      rdc("opctl", IX_OPCTL, 32'h0000);
    end
    $display("test sequences done");
    wr(IX_PROC, 16'h0000);
    chk("offsetEn", 0, offsetEn);
    wr(IX_PROC, 16'h0001);
    chk("offsetEn", 1, offsetEn);
    foreach (codes[i]) begin
      wr(IX_LAYOUT, 16'(codes[i] << 3));
      chk("layout", codes[i], layout);
    end
    foreach (tmp[i]) begin
      illumTemp <= tmp[i];
      repeat (3) @(posedge mclk);
      apb(1'b0, IX_STATUS, 16'h0000);
      chk("ovtBit", ovt[i], rd[ST_OVT]);
      chk("illumEn", ovt[i] == 0, illumEn);
      chk("streamEn", ovt[i] == 0, streamEn);
    end
    wr(IX_OPCTL, 16'h0040);
    rdc("status", IX_STATUS, 32'h0000);
    {sensorFault, illumTempFault, boardTempFault, calibMissing} <= '1;
    repeat (3) @(posedge mclk);
    rdc("status", IX_STATUS, 32'hc028);
    {sensorFault, illumTempFault, boardTempFault} <= '0;
    repeat (3) @(posedge mclk);
    apb(1'b0, IX_STATUS, 16'h0000);
    chk("faultBits", 32'h0, rd & 32'hc008);
    rdc("opctl", IX_OPCTL, 32'h0000);
    $display("test status done");
    wr(IX_IPHI, 16'hc0a8);
    wr(IX_IPLO, 16'h0105);
    wr(IX_MSKHI, 16'hffff);
    wr(IX_MSKLO, 16'hff00);
    wr(IX_GWHI, 16'hc0a8);
    chk("ipAddr", 32'h0, ipAddr);
    wr(IX_GWLO, 16'h0101);
    chk("ipAddr", 32'hc0a80105, ipAddr);
    chk("netMask", 32'hffffff00, netMask);
    chk("gateway", 32'hc0a80101, gateway);
    wr(IX_UDPPRT, 16'h1389);
    chk("udpPort", 32'h1389, udpPort);
    for (int i = 0; i < 3; i++) wr(IX_STN + 16'(i), 16'(16'h0a0b * (i + 1)));
    @(posedge mclk);
    chk("station", 48'h0a0b_1416_1e21, stationAddr);
    base = flN;
    wr(IX_FLCMD, FCMD_SAVE);
    repeat (10) @(posedge mclk);
    chk("lockedReq", base, flN);
    wr(IX_UNLOCK, KEY_FLASH);
    wr(IX_FLCMD, FCMD_SAVE);
    wfl(base);
    chk("saveOp", FOP_SAVE, lastOp);
    base = flN;
    wr(IX_UNLOCK, KEY_FLASH);
    wr(IX_FLCMD, FCMD_ERASE);
    wfl(base);
    chk("eraseOp", FOP_ERASE, lastOp);
    chk("station", STN, stationAddr);
    apb(1'b0, IX_STATUS, 16'h0000);
    chk("factBit", 1, rd[ST_FACT]);
    $display("test network and flash done");
    report_and_stop();
  end
endmodule : tcc_control_regs_test
`default_nettype wire
